// ---- mcc_pkg.sv ----
// Purpose: shared constants for the meter clear-command and information register bank
// Assumes: register indexes are word indexes; byte address is four times the index
// Notes: clear actions travel as one pulse vector whose bit positions are given here
package mcc_pkg;

  // word indexes of the write-only clear command registers
  localparam logic [15:0] IDX_CLR_HIST_MONTH = 16'h2580;
  localparam logic [15:0] IDX_CLR_REALTIME = 16'h2581;
  localparam logic [15:0] IDX_CLR_PRES_MONTH = 16'h2582;
  localparam logic [15:0] IDX_CLR_ALL_ENERGY = 16'h2583;
  localparam logic [15:0] IDX_CLR_SETUP_CNT = 16'h2584;
  localparam logic [15:0] IDX_CLR_MONTH_MAXDMD = 16'h2585;
  localparam logic [15:0] IDX_CLR_ALL_DEMAND = 16'h2586;
  localparam logic [15:0] IDX_CLR_OP_TIME = 16'h2587;
  localparam logic [15:0] IDX_CLR_EVENT_LOG = 16'h2588;
  localparam logic [15:0] IDX_CLR_PULSE1 = 16'h2589;
  localparam logic [15:0] IDX_CLR_PULSE2 = 16'h258A;
  localparam logic [15:0] IDX_CLR_PULSE3 = 16'h258B;
  localparam logic [15:0] IDX_CLR_ALL_PULSE = 16'h258C;
  localparam logic [15:0] IDX_CLR_RECORDER = 16'h258D;
  localparam logic [15:0] IDX_CLR_ALL_DATA = 16'h258E;

  // word indexes of the read-only information registers
  localparam logic [15:0] IDX_MODEL_FIRST = 16'h2648;
  localparam logic [15:0] IDX_FW_VERSION = 16'h265C;
  localparam logic [15:0] IDX_PROTO_VERSION = 16'h265D;
  localparam logic [15:0] IDX_FW_YEAR = 16'h265E;
  localparam logic [15:0] IDX_FW_MONTH = 16'h265F;
  localparam logic [15:0] IDX_FW_DAY = 16'h2660;
  localparam logic [15:0] IDX_SERIAL = 16'h2661;

  // block status and the self-read setting
  localparam logic [15:0] IDX_CLEAR_STATUS = 16'h2590;
  localparam logic [15:0] IDX_SELF_READ = 16'h2591;

  // information memory layout
  localparam int unsigned MODEL_LEN = 20;
  localparam int unsigned ROM_DEPTH = 26;
  localparam int unsigned ROM_AW = 5;
  localparam logic [ROM_AW-1:0] ROM_FW_VERSION = 5'h14;
  localparam logic [ROM_AW-1:0] ROM_PROTO_VERSION = 5'h15;
  localparam logic [ROM_AW-1:0] ROM_FW_YEAR = 5'h16;
  localparam logic [ROM_AW-1:0] ROM_FW_MONTH = 5'h17;
  localparam logic [ROM_AW-1:0] ROM_FW_DAY = 5'h18;
  localparam logic [ROM_AW-1:0] ROM_SERIAL = 5'h19;
  localparam logic [7:0] PAD_CHAR = 8'h20;

  // command words and reset values
  localparam logic [15:0] TRIGGER_WORD = 16'hFF00;
  localparam logic [15:0] SELF_READ_MANUAL = 16'hFFFF;
  localparam logic [15:0] SELF_READ_RESET = 16'h0000;
  localparam logic [3:0] LAST_CMD_NONE = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // clear action pulse vector bit positions
  localparam int unsigned ACT_W = 14;
  localparam int unsigned ACT_HIST_MONTH = 0;
  localparam int unsigned ACT_REALTIME = 1;
  localparam int unsigned ACT_PRES_MONTH = 2;
  localparam int unsigned ACT_SETUP_CNT = 3;
  localparam int unsigned ACT_MONTH_MAXDMD = 4;
  localparam int unsigned ACT_LAST_MAXDMD = 5;
  localparam int unsigned ACT_PRES_DEMAND = 6;
  localparam int unsigned ACT_OP_TIME = 7;
  localparam int unsigned ACT_EVENT_LOG = 8;
  localparam int unsigned ACT_PULSE1 = 9;
  localparam int unsigned ACT_PULSE2 = 10;
  localparam int unsigned ACT_PULSE3 = 11;
  localparam int unsigned ACT_RECORDER = 12;
  localparam int unsigned ACT_DMD_TRANSFER = 13;

  typedef logic [ACT_W-1:0] mcc_act_t;

endpackage

// ---- mcc_info_rom.sv ----
// Purpose: constant store for model name, versions, firmware date and serial number
// Assumes: one read per enable, data valid on the cycle after the enable
// Notes: contents come from parameters only; no file is loaded
`timescale 1ns/1ps
module mcc_info_rom
  import mcc_pkg::*;
#(
  parameter logic [8*MODEL_LEN-1:0] MODEL_NAME = "UNIT1               ", // arbitrary
  parameter int unsigned FW_MAJOR = 1,
  parameter int unsigned FW_MINOR = 0,
  parameter int unsigned FW_PATCH = 0,
  parameter int unsigned PROTO_MAJOR = 1,
  parameter int unsigned PROTO_MINOR = 0,
  parameter int unsigned FW_YEAR = 2000,
  parameter int unsigned FW_MONTH = 1,
  parameter int unsigned FW_DAY = 1,
  parameter logic [31:0] SERIAL = 32'h0000_0001 // arbitrary
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic en, // read strobe
  input wire logic [ROM_AW-1:0] addr, // word within the store
  output logic [31:0] q // registered read data
);
  typedef struct packed {
    logic [31:0] q;
  } mcc_rom_state_t;

  mcc_rom_state_t s;
  mcc_rom_state_t next_s;

  // one entry of the store; blank name bytes read back as spaces
  function automatic logic [31:0] entry(input logic [ROM_AW-1:0] a);
    logic [7:0] c;
    c = 8'h00;
    entry = 32'h0000_0000;
    if (int'(a) < MODEL_LEN) begin
      c = MODEL_NAME[8*(MODEL_LEN-1-int'(a)) +: 8];
      entry = {24'h00_0000, (c == 8'h00) ? PAD_CHAR : c};
    end else begin
      unique case (a)
        ROM_FW_VERSION: entry = 32'(FW_MAJOR*10000 + FW_MINOR*100 + FW_PATCH);
        ROM_PROTO_VERSION: entry = 32'(PROTO_MAJOR*10 + PROTO_MINOR);
        ROM_FW_YEAR: entry = 32'(FW_YEAR - 2000);
        ROM_FW_MONTH: entry = 32'(FW_MONTH);
        ROM_FW_DAY: entry = 32'(FW_DAY);
        ROM_SERIAL: entry = SERIAL;
        default: entry = 32'h0000_0000;
      endcase
    end
  endfunction

  // read data is held until the next strobe
  always_comb begin
    next_s = s;
    if (en) begin
      next_s.q = entry(addr);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule

// ---- mcc_clear_ctrl.sv ----
// Purpose: clear-command and meter information registers behind an AXI4-Lite slave
// Assumes: one write and one read under way at a time; byte address = word index * 4
// Notes: clear actions leave as one-cycle pulses on CLR_ACTION for the meter logic
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module mcc_clear_ctrl
  import mcc_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter logic [8*MODEL_LEN-1:0] MODEL_NAME = "UNIT1               ", // arbitrary
  parameter int unsigned FW_MAJOR = 1,
  parameter int unsigned FW_MINOR = 0,
  parameter int unsigned FW_PATCH = 0,
  parameter int unsigned PROTO_MAJOR = 1,
  parameter int unsigned PROTO_MINOR = 0,
  parameter int unsigned FW_YEAR = 2000,
  parameter int unsigned FW_MONTH = 1,
  parameter int unsigned FW_DAY = 1,
  parameter logic [31:0] SERIAL = 32'h0000_0001 // arbitrary
) (
  input wire logic CLK, // 50 MHz system clock
  input wire logic RST_B, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write byte address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte enables
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read byte address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  output mcc_act_t CLR_ACTION // one-cycle clear pulses, see package
);
  typedef struct packed {
    logic aw_held;
    logic [15:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_wait;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    mcc_act_t clr;
    logic month_defer;
    logic [3:0] last_cmd;
    logic [15:0] clr_count;
    logic [15:0] self_read;
  } mcc_state_t;

  localparam mcc_state_t STATE_RESET = '{
    aw_held: 1'b0, aw_idx: 16'h0000, w_held: 1'b0, wdata: 32'h0000_0000,
    wstrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rd_wait: 1'b0,
    rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY, clr: '0,
    month_defer: 1'b0, last_cmd: LAST_CMD_NONE, clr_count: 16'h0000,
    self_read: SELF_READ_RESET
  };

  mcc_state_t s;
  mcc_state_t next_s;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [15:0] ar_idx;
  logic ar_info;
  logic rom_en;
  logic [ROM_AW-1:0] rom_addr;
  logic [31:0] rom_q;

  // byte address to word index; low two address bits are ignored
  function automatic logic [15:0] to_idx(input logic [ADDR_W-1:0] a);
    to_idx = 16'(a >> 2);
  endfunction

  // true for indexes held in the information store
  function automatic logic is_info(input logic [15:0] idx);
    is_info = (idx >= IDX_MODEL_FIRST) && (idx <= IDX_SERIAL);
  endfunction

  // true for the write-only clear command registers
  function automatic logic is_clear(input logic [15:0] idx);
    is_clear = (idx >= IDX_CLR_HIST_MONTH) && (idx <= IDX_CLR_ALL_DATA);
  endfunction

  // clear actions carried out by each command register
  function automatic mcc_act_t clear_map(input logic [15:0] idx);
    mcc_act_t a;
    mcc_act_t energy;
    mcc_act_t demand;
    mcc_act_t pulses;
    a = '0;
    energy = '0;
    demand = '0;
    pulses = '0;
    energy[ACT_REALTIME] = 1'b1;
    energy[ACT_HIST_MONTH] = 1'b1;
    energy[ACT_PRES_MONTH] = 1'b1;
    demand[ACT_PRES_DEMAND] = 1'b1;
    demand[ACT_MONTH_MAXDMD] = 1'b1;
    demand[ACT_LAST_MAXDMD] = 1'b1;
    pulses[ACT_PULSE1] = 1'b1;
    pulses[ACT_PULSE2] = 1'b1;
    pulses[ACT_PULSE3] = 1'b1;
    unique case (idx)
      IDX_CLR_HIST_MONTH: a[ACT_HIST_MONTH] = 1'b1;
      IDX_CLR_REALTIME: a[ACT_REALTIME] = 1'b1;
      IDX_CLR_PRES_MONTH: a[ACT_PRES_MONTH] = 1'b1;
      IDX_CLR_ALL_ENERGY: a = energy;
      IDX_CLR_SETUP_CNT: a[ACT_SETUP_CNT] = 1'b1;
      IDX_CLR_MONTH_MAXDMD: a[ACT_MONTH_MAXDMD] = 1'b1;
      IDX_CLR_ALL_DEMAND: a = demand;
      IDX_CLR_OP_TIME: a[ACT_OP_TIME] = 1'b1;
      IDX_CLR_EVENT_LOG: a[ACT_EVENT_LOG] = 1'b1;
      IDX_CLR_PULSE1: a[ACT_PULSE1] = 1'b1;
      IDX_CLR_PULSE2: a[ACT_PULSE2] = 1'b1;
      IDX_CLR_PULSE3: a[ACT_PULSE3] = 1'b1;
      IDX_CLR_ALL_PULSE: a = pulses;
      IDX_CLR_RECORDER: a[ACT_RECORDER] = 1'b1;
      IDX_CLR_ALL_DATA: begin
        a = energy | demand | pulses;
        a[ACT_SETUP_CNT] = 1'b1;
        a[ACT_OP_TIME] = 1'b1;
        a[ACT_EVENT_LOG] = 1'b1;
        a[ACT_RECORDER] = 1'b1;
      end
      default: a = '0;
    endcase
    clear_map = a;
  endfunction

  // merge a 16-bit register with the low byte lanes of a write
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  // channel handshakes; one write and one read outstanding at most
  assign S_AXI_AWREADY = !s.aw_held && !s.bvalid;
  assign S_AXI_WREADY = !s.w_held && !s.bvalid;
  assign S_AXI_ARREADY = !s.rd_wait && !s.rvalid;
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;

  // information reads go through the registered store, one cycle later
  assign ar_idx = to_idx(S_AXI_ARADDR);
  assign ar_info = is_info(ar_idx);
  assign rom_en = ar_hs && ar_info;
  assign rom_addr = ROM_AW'(ar_idx - IDX_MODEL_FIRST);

  mcc_info_rom #(
    .MODEL_NAME(MODEL_NAME),
    .FW_MAJOR(FW_MAJOR),
    .FW_MINOR(FW_MINOR),
    .FW_PATCH(FW_PATCH),
    .PROTO_MAJOR(PROTO_MAJOR),
    .PROTO_MINOR(PROTO_MINOR),
    .FW_YEAR(FW_YEAR),
    .FW_MONTH(FW_MONTH),
    .FW_DAY(FW_DAY),
    .SERIAL(SERIAL)
  ) u_info (
    .clk(CLK),
    .rst_b(RST_B),
    .en(rom_en),
    .addr(rom_addr),
    .q(rom_q)
  );

  // next-state logic for both channels and the clear sequencer
  always_comb begin
    mcc_act_t act;
    act = '0;
    next_s = s;
    next_s.clr = '0;
    // second half of a manual-mode demand clear: the copy went out last cycle
    if (s.month_defer) begin
      next_s.clr[ACT_MONTH_MAXDMD] = 1'b1;
      next_s.month_defer = 1'b0;
    end
    // write address and data may arrive in either order
    if (aw_hs) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = to_idx(S_AXI_AWADDR);
    end
    if (w_hs) begin
      next_s.w_held = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // both halves held: act on the write and answer it
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (is_clear(s.aw_idx)) begin
        // a partial or wrong word is accepted but fires nothing
        if (s.wdata[15:0] == TRIGGER_WORD && s.wstrb[1:0] == 2'h3) begin
          act = clear_map(s.aw_idx);
          // manual self-read copies this month into last month before clearing
          if (act[ACT_MONTH_MAXDMD] && !act[ACT_LAST_MAXDMD]
              && s.self_read == SELF_READ_MANUAL) begin
            act[ACT_MONTH_MAXDMD] = 1'b0;
            act[ACT_DMD_TRANSFER] = 1'b1;
            next_s.month_defer = 1'b1;
          end
          next_s.clr = next_s.clr | act;
          next_s.last_cmd = 4'(s.aw_idx - IDX_CLR_HIST_MONTH);
          next_s.clr_count = s.clr_count + 16'h0001;
        end
      end else if (s.aw_idx == IDX_SELF_READ) begin
        next_s.self_read = merge16(s.self_read, s.wdata, s.wstrb);
      end else begin
        // information and clear status registers are read-only; other indexes are unmapped
        next_s.bresp = RESP_SLVERR;
      end
    end
    // read channel
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (s.rd_wait) begin
      next_s.rd_wait = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rom_q;
      next_s.rresp = RESP_OKAY;
    end
    if (ar_hs) begin
      if (ar_info) begin
        next_s.rd_wait = 1'b1;
      end else begin
        next_s.rvalid = 1'b1;
        next_s.rresp = RESP_OKAY;
        if (is_clear(ar_idx)) begin
          next_s.rdata = 32'h0000_0000;
        end else if (ar_idx == IDX_CLEAR_STATUS) begin
          next_s.rdata = {s.clr_count, 12'h000, s.last_cmd};
        end else if (ar_idx == IDX_SELF_READ) begin
          next_s.rdata = {16'h0000, s.self_read};
        end else begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      end
    end
  end

  // state register; synchronous reset to constants only
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // response, read data and action outputs come straight from the state register; the ready outputs are gated from it
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;
  assign CLR_ACTION = s.clr;
endmodule

// ---- mcc_clear_ctrl_checker.sv ----
// Purpose: checks each clear pulse against the write that caused it
// Assumes: one write outstanding, so the captured address belongs to the next response
// Notes: self-read mode is tracked only from writes with both low byte lanes enabled, as the bench makes them
`timescale 1ns/1ps
module mcc_clear_ctrl_checker #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic CLK, // system clock
  input wire logic RST_B, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write byte address
  input wire logic S_AXI_AWVALID, // write address valid
  input wire logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // byte enables
  input wire logic S_AXI_WVALID, // write data valid
  input wire logic S_AXI_WREADY, // write data ready
  input wire logic [1:0] S_AXI_BRESP, // write response
  input wire logic S_AXI_BVALID, // write response valid
  input wire mcc_pkg::mcc_act_t CLR_ACTION // clear pulses
);
  import mcc_pkg::*;
  logic [15:0] ai;
  logic [15:0] wd;
  logic [15:0] sr;
  logic [1:0] ws;
  logic pb;
  logic fire;
  logic hit;
  logic man;
  // capture the write in flight; the response edge is judged against it
  always_ff @(posedge CLK) begin
    pb <= S_AXI_BVALID;
    if (S_AXI_AWVALID && S_AXI_AWREADY) ai <= 16'(S_AXI_AWADDR >> 2);
    if (S_AXI_WVALID && S_AXI_WREADY) wd <= S_AXI_WDATA[15:0];
    if (S_AXI_WVALID && S_AXI_WREADY) ws <= S_AXI_WSTRB[1:0];
    if (!RST_B) sr <= SELF_READ_RESET;
    else if (fire && ai == IDX_SELF_READ && ws == 2'b11) sr <= wd;
  end
  // first cycle of a response, and whether it carried the trigger
  assign fire = S_AXI_BVALID && !pb;
  assign hit = fire && wd == TRIGGER_WORD && ws == 2'b11;
  assign man = sr == SELF_READ_MANUAL;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_hist; hit && ai == IDX_CLR_HIST_MONTH |-> CLR_ACTION == 14'h0001; endproperty
  a_hist: assert property (p_hist) else $error("history clear pulse wrong");
  property p_rt; hit && ai == IDX_CLR_REALTIME |-> CLR_ACTION == 14'h0002; endproperty
  a_rt: assert property (p_rt) else $error("realtime clear pulse wrong");
  property p_pres; hit && ai == IDX_CLR_PRES_MONTH |-> CLR_ACTION == 14'h0004; endproperty
  a_pres: assert property (p_pres) else $error("present month pulse wrong");
  property p_allen; hit && ai == IDX_CLR_ALL_ENERGY |-> CLR_ACTION == 14'h0007; endproperty
  a_allen: assert property (p_allen) else $error("all energy pulse wrong");
  property p_setup; hit && ai == IDX_CLR_SETUP_CNT |-> CLR_ACTION == 14'h0008; endproperty
  a_setup: assert property (p_setup) else $error("setup clear pulse wrong");
  property p_auto; hit && ai == IDX_CLR_MONTH_MAXDMD && !man |-> CLR_ACTION == 14'h0010;
  endproperty
  a_auto: assert property (p_auto) else $error("automatic demand clear wrong");
  property p_man; hit && ai == IDX_CLR_MONTH_MAXDMD && man
    |-> CLR_ACTION == 14'h2000 ##1 CLR_ACTION == 14'h0010; endproperty
  a_man: assert property (p_man) else $error("manual demand copy wrong");
  property p_alldmd; hit && ai == IDX_CLR_ALL_DEMAND |-> CLR_ACTION == 14'h0070; endproperty
  a_alldmd: assert property (p_alldmd) else $error("all demand pulse wrong");
  property p_opev; hit && (ai == IDX_CLR_OP_TIME || ai == IDX_CLR_EVENT_LOG)
    |-> CLR_ACTION == (ai == IDX_CLR_OP_TIME ? 14'h0080 : 14'h0100); endproperty
  a_opev: assert property (p_opev) else $error("time or event clear wrong");
  property p_pulse; hit && ai inside {[IDX_CLR_PULSE1:IDX_CLR_ALL_PULSE]} |-> CLR_ACTION ==
    (ai == IDX_CLR_ALL_PULSE ? 14'h0E00 : 14'(14'h0200 << (ai - IDX_CLR_PULSE1))); endproperty
  a_pulse: assert property (p_pulse) else $error("pulse counter clear wrong");
  property p_rec; hit && ai == IDX_CLR_RECORDER |-> CLR_ACTION == 14'h1000; endproperty
  a_rec: assert property (p_rec) else $error("recorder clear wrong");
  property p_all; hit && ai == IDX_CLR_ALL_DATA
    |-> CLR_ACTION == 14'h1FFF ##1 CLR_ACTION == 14'h0000; endproperty
  a_all: assert property (p_all) else $error("all data clear wrong");
  property p_none; $rose(S_AXI_BVALID) && !hit |-> CLR_ACTION == 14'h0000; endproperty
  a_none: assert property (p_none) else $error("pulse without trigger");
endmodule
bind mcc_clear_ctrl mcc_clear_ctrl_checker #(.ADDR_W(ADDR_W)) u_checker (
  .CLK(CLK), .RST_B(RST_B), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .CLR_ACTION(CLR_ACTION));

// ---- mcc_host_model.sv ----
// Purpose: host software stand-in issuing register writes and reads over AXI4-Lite
// Assumes: one caller at a time; one write or one read outstanding
// Notes: outputs change only just after a rising edge; a lost answer raises hung
`timescale 1ns/1ps
module mcc_host_model (
  input wire logic clk, // system clock
  output logic [15:0] awaddr, // write byte address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // byte enables
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [15:0] araddr, // read byte address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic rvalid, // read data valid
  output logic rready, // read data ready
  output logic hung // no answer within the limit
);
  localparam int LIMIT = 50;
  // idle bus at time zero
  initial begin
    {awaddr, araddr, wdata, wstrb} = 68'h0;
    {awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {idx[13:0], 2'b00};
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < LIMIT);
    bready <= 1'b0;
    if (!bvalid) hung <= 1'b1;
  endtask
  // read address held until taken, rready until the data arrive
  task automatic rd(input logic [15:0] idx);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx[13:0], 2'b00};
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < LIMIT);
    rready <= 1'b0;
    if (!rvalid) hung <= 1'b1;
  endtask
endmodule

// ---- mcc_clear_ctrl_tb_top.sv ----
// Purpose: drives clear commands and information reads, matching every response
// Assumes: noted results arrive in the order they were issued, per kind
// Notes: information values are the bench's own arbitrary parameters
`timescale 1ns/1ps
module mcc_clear_ctrl_tb_top;
  import mcc_pkg::*;
  localparam logic [159:0] MNAME = "QX9                 "; // arbitrary
  localparam logic [31:0] SER = 32'h5A17_0C3E; // arbitrary
  localparam logic [33:0] NONE = 34'h3_0000_0000;
  logic CLK, RST_B, HUNG, AWV, WV, BV, BR, ARV, RV, RR, AWR, WR, ARR;
  logic [15:0] AWA, ARA;
  logic [31:0] WD, RD;
  logic [3:0] WS;
  logic [1:0] BRESP, RRESP;
  mcc_act_t ACT;
  mcc_act_t act_tab [15];
  logic [33:0] q_r [$];
  logic [1:0] q_b [$];
  mcc_act_t q_a [$];
  int num_errors = 0;
  int n_compared = 0;
  // five overrides; the other info fields keep their defaults so both paths are read
  mcc_clear_ctrl #(.MODEL_NAME(MNAME), .FW_MINOR(13), .PROTO_MINOR(4), .FW_YEAR(2024),
    .SERIAL(SER)) DUT (.CLK(CLK), .RST_B(RST_B), .S_AXI_AWADDR(AWA), .S_AXI_AWVALID(AWV),
    .S_AXI_AWREADY(AWR), .S_AXI_WDATA(WD), .S_AXI_WSTRB(WS), .S_AXI_WVALID(WV),
    .S_AXI_WREADY(WR), .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BV), .S_AXI_BREADY(BR),
    .S_AXI_ARADDR(ARA), .S_AXI_ARVALID(ARV), .S_AXI_ARREADY(ARR), .S_AXI_RDATA(RD),
    .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RV), .S_AXI_RREADY(RR), .CLR_ACTION(ACT));
  mcc_host_model HOST (.clk(CLK), .awaddr(AWA), .awvalid(AWV), .awready(AWR), .wdata(WD),
    .wstrb(WS), .wvalid(WV), .wready(WR), .bvalid(BV), .bready(BR), .araddr(ARA),
    .arvalid(ARV), .arready(ARR), .rvalid(RV), .rready(RR), .hung(HUNG));
  always #10 CLK = ~CLK;
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // note the response, then run the write
  task automatic wr(input logic [15:0] ix, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    q_b.push_back(r);
    HOST.wr(ix, d, s);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [33:0] want);
    q_r.push_back(want);
    HOST.rd(ix);
  endtask
  // results matched against the oldest note of their kind; stray pulses fail
  always @(posedge CLK) begin
    if (HUNG) num_errors++;
    if (HUNG) complete_run();
    if (RST_B && BV && BR) check(34'(BRESP), q_b.size() ? 34'(q_b.pop_front()) : NONE);
    if (RST_B && RV && RR) check({RRESP, RD}, q_r.size() ? q_r.pop_front() : NONE);
    if (RST_B && ACT !== 14'h0) check(34'(ACT), q_a.size() ? 34'(q_a.pop_front()) : 34'h0);
  end
  // main sequence
  initial begin
    logic [31:0] d;
    logic [15:0] ix;
    CLK = 1'b0;
    RST_B = 1'b0;
    act_tab = '{14'h0001, 14'h0002, 14'h0004, 14'h0007, 14'h0008, 14'h0010, 14'h0070,
      14'h0080, 14'h0100, 14'h0200, 14'h0400, 14'h0800, 14'h0E00, 14'h1000, 14'h1FFF};
    void'($urandom(56));
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    // every clear command, random upper half which must be ignored
    for (int k = 0; k < 15; k++) begin
      q_a.push_back(act_tab[k]);
      wr(IDX_CLR_HIST_MONTH + 16'(k), {16'($urandom), TRIGGER_WORD}, 4'hF, RESP_OKAY);
    end
    // manual self-read: copy first, then clear
    wr(IDX_SELF_READ, 32'h0000_FFFF, 4'hF, RESP_OKAY);
    rd(IDX_SELF_READ, {RESP_OKAY, 32'h0000_FFFF});
    q_a.push_back(14'h2000);
    q_a.push_back(14'h0010);
    wr(IDX_CLR_MONTH_MAXDMD, 32'h0000_FF00, 4'hF, RESP_OKAY);
    wr(IDX_SELF_READ, 32'h0, 4'hF, RESP_OKAY);
    // wrong words, partial strobe and reads of command registers do nothing
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      if (d[15:0] == TRIGGER_WORD) d[0] = 1'b1;
      ix = IDX_CLR_HIST_MONTH + 16'($urandom % 15);
      wr(ix, d, 4'hF, RESP_OKAY);
      rd(ix, {RESP_OKAY, 32'h0});
    end
    wr(IDX_CLR_ALL_DATA, 32'h0000_FF00, 4'h1, RESP_OKAY);
    // information registers, refused writes and an unmapped place
    for (int k = 0; k < 20; k++) rd(IDX_MODEL_FIRST + 16'(k), {RESP_OKAY, 24'h0, MNAME[159-8*k -: 8]});
    rd(IDX_FW_VERSION, {RESP_OKAY, 32'd11300});
    rd(IDX_PROTO_VERSION, {RESP_OKAY, 32'd14});
    rd(IDX_FW_YEAR, {RESP_OKAY, 32'd24});
    rd(IDX_FW_MONTH, {RESP_OKAY, 32'd1});
    rd(IDX_FW_DAY, {RESP_OKAY, 32'd1});
    rd(IDX_SERIAL, {RESP_OKAY, SER});
    rd(16'h2662, {RESP_SLVERR, 32'h0});
    wr(IDX_FW_VERSION, 32'h0000_FF00, 4'hF, RESP_SLVERR);
    wr(16'h2600, 32'h0000_FF00, 4'hF, RESP_SLVERR);
    rd(IDX_FW_VERSION, {RESP_OKAY, 32'd11300});
    repeat (4) @(posedge CLK);
    check(34'(q_a.size() + q_b.size() + q_r.size()), 34'h0);
    complete_run();
  end
endmodule
